// [hdl/rpw_pkg.sv]
/*
 * Shared constants for the replay-protected write engine: frame byte
 * offsets, message types, result codes and counter limits.
 * Assumes frames are handled as byte streams indexed from byte 0.
 */
package rpw_pkg;

  // ---------------------------------------------------------------
  // Frame layout (byte indices)
  // ---------------------------------------------------------------
  localparam logic [31:0] FR_MAC_LO   = 32'h0000_00bf;
  localparam logic [31:0] FR_TGT      = 32'h0000_00df;
  localparam logic [31:0] FR_NONCE_LO = 32'h0000_00e0;
  localparam logic [31:0] FR_NONCE_HI = 32'h0000_00ef;
  localparam logic [31:0] FR_CNT_LO   = 32'h0000_00f0;
  localparam logic [31:0] FR_CNT_HI   = 32'h0000_00f3;
  localparam logic [31:0] FR_ADR_LO   = 32'h0000_00f4;
  localparam logic [31:0] FR_ADR_HI   = 32'h0000_00f7;
  localparam logic [31:0] FR_SC_LO    = 32'h0000_00f8;
  localparam logic [31:0] FR_SC_HI    = 32'h0000_00fb;
  localparam logic [31:0] FR_RES_LO   = 32'h0000_00fc;
  localparam logic [31:0] FR_RES_HI   = 32'h0000_00fd;
  localparam logic [31:0] FR_TYP_LO   = 32'h0000_00fe;
  localparam logic [31:0] FR_TYP_HI   = 32'h0000_00ff;
  localparam logic [31:0] FR_LEN      = 32'h0000_0100;

  // ---------------------------------------------------------------
  // Message types
  // ---------------------------------------------------------------
  localparam logic [15:0] REQ_CNT_READ = 16'h0002;
  localparam logic [15:0] REQ_WRITE    = 16'h0003;
  localparam logic [15:0] REQ_RESULT   = 16'h0005;
  localparam logic [15:0] RSP_CNT_READ = 16'h0200;
  localparam logic [15:0] RSP_WRITE    = 16'h0300;

  // ---------------------------------------------------------------
  // Result codes
  // ---------------------------------------------------------------
  localparam logic [15:0] RES_OK      = 16'h0000;
  localparam logic [15:0] RES_GENERAL = 16'h0001;
  localparam logic [15:0] RES_AUTH    = 16'h0002;
  localparam logic [15:0] RES_COUNTER = 16'h0003;
  localparam logic [15:0] RES_ADDRESS = 16'h0004;
  localparam logic [15:0] RES_WRFAIL  = 16'h0005;
  localparam logic [15:0] RES_EXPIRED = 16'h0085;

  // ---------------------------------------------------------------
  // Counter, reset and area size values
  // ---------------------------------------------------------------
  localparam logic [31:0] CNT_MAX     = 32'hffff_ffff;
  localparam logic [31:0] CNT_RESET   = 32'h0000_0000;
  localparam logic [31:0] AREA_BLOCKS = 32'h0000_0100;

  typedef enum logic [3:0] {
    ST_IDLE, ST_RX, ST_EVAL, ST_MAC, ST_COMMIT,
    ST_GEN, ST_GEN_WAIT, ST_TX, ST_DRAIN
  } rpw_state_t;

endpackage

// [hdl/rpw_stream_if.sv]
/*
 * Valid/ready byte stream carrier between the engine and its buffer.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface rpw_stream_if #(
  parameter int W = 8
);
  logic         valid;
  logic         ready;
  logic         last;
  logic [W-1:0] data;

  modport src (output valid, output data, output last, input ready);
  modport snk (input valid, input data, input last, output ready);
endinterface

// [hdl/rpw_buf.sv]
/*
 * Small shift FIFO with valid/ready on both sides; head entry is a flop.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module rpw_buf #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic   sys_clk,
  input  wire logic   sys_rst,
  // Streams
  rpw_stream_if.snk   s_in,
  rpw_stream_if.src   s_out
);
  import rpw_pkg::*;

  localparam int CW = $clog2(DEPTH + 1);

  logic [W:0]    mem_reg  [DEPTH];
  logic [W:0]    mem_next [DEPTH];
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          push;
  logic          pop;
  logic [CW-1:0] wpos;

  // ---------------------------------------------------------------
  // Occupancy and storage
  // ---------------------------------------------------------------
  assign s_in.ready  = (cnt_reg != CW'(DEPTH));
  assign s_out.valid = (cnt_reg != '0);
  assign s_out.data  = mem_reg[0][W-1:0];
  assign s_out.last  = mem_reg[0][W];

  always_comb begin
    push = s_in.valid && s_in.ready;
    pop  = s_out.valid && s_out.ready;
    wpos = cnt_reg - CW'(pop);
    for (int i = 0; i < DEPTH; i++) begin
      // Shift toward the head so the output stays a plain flop
      if (pop && i < DEPTH - 1) begin
        mem_next[i] = mem_reg[i + 1];
      end else begin
        mem_next[i] = mem_reg[i];
      end
      if (push && CW'(i) == wpos) begin
        mem_next[i] = {s_in.last, s_in.data};
      end
    end
    cnt_next = cnt_reg + CW'(push) - CW'(pop);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_reg <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
    end else begin
      cnt_reg <= cnt_next;
      mem_reg <= mem_next;
    end
  end

endmodule

// [hdl/rpw_engine.sv]
/*
 * Replay-protected area command engine: parses security send frames,
 * runs the counter-read, authenticated-write and result-query flows,
 * and returns response frames for security receive.
 * Assumes an outside MAC engine, a media unit that stages payload bytes,
 * and that every input comes from logic on sys_clk.
 */
// Function
// RULE1: counter read is a send request followed by a receive fetch.
// RULE2: host counter-read request carries nonce and type 0002h, rest zero.
// RULE3: counter-read response echoes nonce, counter, MAC, target, result, type 0200h.
// RULE4: host write request type 0003h carries count, address, counter, data, MAC.
// RULE5: expired counter first gives 0085h, area untouched.
// RULE6: then bad address gives 0004h, nothing written.
// RULE7: then MAC mismatch gives 0002h, nothing written.
// RULE8: then counter mismatch gives 0003h, nothing written.
// RULE9: all checks pass: commit payload, counter plus exactly one.
// RULE10: media failure gives 0005h, other write errors give 0001h.
// RULE11: write send completes once finished, whatever the outcome.
// RULE12: host verifies a write with a send request of type 0005h.
// RULE13: verification send completes only when the result is fetchable.
// RULE14: host then issues a receive to collect the write outcome.
// RULE15: verification response type 0300h: counter, address, MAC, result.
// RULE16: MAC covers bytes 223 to 255 then data, with stored key.
// RULE17: no command completes before its operation has fully finished.
// RULE18: checks run in order; first failure alone sets the result.
`timescale 1ns/1ps
module rpw_engine #(
  parameter logic [31:0] AREA_SIZE = rpw_pkg::AREA_BLOCKS
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  // Security send frame in
  input  wire logic         rx_valid,
  input  wire logic [7:0]   rx_data,
  input  wire logic         rx_last,
  output logic              rx_ready,
  output logic              send_done,
  // Security receive frame out
  input  wire logic         rcv_req,
  output logic              tx_valid,
  output logic [7:0]        tx_data,
  output logic              tx_last,
  input  wire logic         tx_ready,
  output logic              rcv_done,
  // MAC engine
  output logic              mac_valid,
  output logic [7:0]        mac_data,
  output logic              mac_last,
  output logic              mac_gen,
  output logic              mac_chk_req,
  input  wire logic         mac_chk_done,
  input  wire logic         mac_chk_ok,
  input  wire logic         mac_gen_done,
  input  wire logic [255:0] mac_gen_value,
  // Media unit
  output logic              stg_valid,
  output logic [7:0]        stg_data,
  output logic              med_commit,
  output logic [31:0]       med_addr,
  output logic [31:0]       med_count,
  input  wire logic         med_done,
  input  wire logic         med_fail,
  input  wire logic         med_err,
  // Status
  output logic [31:0]       wr_counter,
  output logic              busy
);
  import rpw_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic in_rng(input logic [31:0] i, input logic [31:0] lo,
                                  input logic [31:0] hi);
    in_rng = (i >= lo) && (i <= hi);
  endfunction

  function automatic logic [7:0] pick(input logic [255:0] v, input logic [31:0] off);
    logic [255:0] s;
    s = v >> {off[4:0], 3'b000};
    pick = s[7:0];
  endfunction

  // Response byte; stuff bytes and unused fields read as zero
  function automatic logic [7:0] resp_byte(input logic [31:0] i, input logic [15:0] typ,
                                           input logic [15:0] res, input logic [31:0] cnt,
                                           input logic [31:0] adr, input logic [127:0] non,
                                           input logic [7:0] tgt, input logic [255:0] mac);
    resp_byte = 8'h00;
    if (in_rng(i, FR_MAC_LO, FR_TGT - 32'h0000_0001)) begin
      resp_byte = pick(mac, i - FR_MAC_LO);
    end else if (i == FR_TGT) begin
      resp_byte = tgt;
    end else if (in_rng(i, FR_NONCE_LO, FR_NONCE_HI)) begin
      resp_byte = pick({128'h0, non}, i - FR_NONCE_LO);
    end else if (in_rng(i, FR_CNT_LO, FR_CNT_HI)) begin
      resp_byte = pick({224'h0, cnt}, i - FR_CNT_LO);
    end else if (in_rng(i, FR_ADR_LO, FR_ADR_HI)) begin
      resp_byte = pick({224'h0, adr}, i - FR_ADR_LO);
    end else if (in_rng(i, FR_RES_LO, FR_RES_HI)) begin
      resp_byte = pick({240'h0, res}, i - FR_RES_LO);
    end else if (in_rng(i, FR_TYP_LO, FR_TYP_HI)) begin
      resp_byte = pick({240'h0, typ}, i - FR_TYP_LO);
    end
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  rpw_state_t     st_reg,      st_next;
  logic [31:0]    idx_reg,     idx_next;
  logic [7:0]     tgt_reg,     tgt_next;
  logic [127:0]   nonce_reg,   nonce_next;
  logic [31:0]    qcnt_reg,    qcnt_next;
  logic [31:0]    qadr_reg,    qadr_next;
  logic [31:0]    qsc_reg,     qsc_next;
  logic [15:0]    qtyp_reg,    qtyp_next;
  logic           short_reg,   short_next;
  logic [31:0]    ctr_reg,     ctr_next;
  logic [15:0]    wres_reg,    wres_next;
  logic [31:0]    wadr_reg,    wadr_next;
  logic [15:0]    rtyp_reg,    rtyp_next;
  logic [15:0]    rres_reg,    rres_next;
  logic [31:0]    radr_reg,    radr_next;
  logic [127:0]   rnon_reg,    rnon_next;
  logic [255:0]   rmac_reg,    rmac_next;
  logic           pend_reg,    pend_next;
  logic           rdy_reg,     rdy_next;
  logic           sdone_reg,   sdone_next;
  logic           rdone_reg,   rdone_next;
  logic           mval_reg,    mval_next;
  logic [7:0]     mdat_reg,    mdat_next;
  logic           mlast_reg,   mlast_next;
  logic           mgen_reg,    mgen_next;
  logic           mreq_reg,    mreq_next;
  logic           sval_reg,    sval_next;
  logic [7:0]     sdat_reg,    sdat_next;
  logic           commit_reg,  commit_next;
  logic           take;
  logic [7:0]     rbyte;

  rpw_stream_if #(.W(8)) b_in ();
  rpw_stream_if #(.W(8)) b_out ();

  rpw_buf #(.W(8), .DEPTH(2)) u_buf (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .s_in    (b_in),
    .s_out   (b_out)
  );

  assign rbyte       = resp_byte(idx_reg, rtyp_reg, rres_reg, ctr_reg, radr_reg,
                                 rnon_reg, tgt_reg, rmac_reg);
  assign b_in.valid  = (st_reg == ST_TX);
  assign b_in.data   = rbyte;
  assign b_in.last   = (idx_reg == FR_TYP_HI);
  assign b_out.ready = tx_ready;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;       idx_next = idx_reg;     tgt_next = tgt_reg;
    nonce_next = nonce_reg; qcnt_next = qcnt_reg;   qadr_next = qadr_reg;
    qsc_next = qsc_reg;     qtyp_next = qtyp_reg;   short_next = short_reg;
    ctr_next = ctr_reg;     wres_next = wres_reg;   wadr_next = wadr_reg;
    rtyp_next = rtyp_reg;   rres_next = rres_reg;   radr_next = radr_reg;
    rnon_next = rnon_reg;   rmac_next = rmac_reg;   rdy_next = rdy_reg;
    mdat_next = mdat_reg;   mgen_next = mgen_reg;   sdat_next = sdat_reg;
    sdone_next = 1'b0;      rdone_next = 1'b0;      mval_next = 1'b0;
    mlast_next = 1'b0;      mreq_next = 1'b0;       sval_next = 1'b0;
    commit_next = 1'b0;
    // Set beats clear so a request in the servicing cycle is kept
    pend_next = pend_reg || rcv_req;
    take = rx_valid && rdy_reg;

    unique case (st_reg)
      ST_IDLE: begin
        idx_next   = '0;
        short_next = 1'b0;
        if (pend_reg) begin
          pend_next = rcv_req;
          rdy_next  = 1'b0;
          idx_next  = FR_TGT;
          mgen_next = 1'b1;
          st_next   = ST_GEN;
        end else begin
          rdy_next = 1'b1;
          st_next  = ST_RX;
        end
      end
      ST_RX: begin
        if (take) begin
          idx_next = idx_reg + 32'h0000_0001;
          if (idx_reg == FR_TGT) tgt_next = rx_data;
          if (in_rng(idx_reg, FR_NONCE_LO, FR_NONCE_HI)) nonce_next = {rx_data, nonce_reg[127:8]};
          if (in_rng(idx_reg, FR_CNT_LO, FR_CNT_HI)) qcnt_next = {rx_data, qcnt_reg[31:8]};
          if (in_rng(idx_reg, FR_ADR_LO, FR_ADR_HI)) qadr_next = {rx_data, qadr_reg[31:8]};
          if (in_rng(idx_reg, FR_SC_LO, FR_SC_HI)) qsc_next = {rx_data, qsc_reg[31:8]};
          if (in_rng(idx_reg, FR_TYP_LO, FR_TYP_HI)) qtyp_next = {rx_data, qtyp_reg[15:8]};
          // MAC input stream: received MAC, fields 223..255, then data
          if (idx_reg >= FR_MAC_LO) begin                              // RULE16
            mval_next  = 1'b1;
            mdat_next  = rx_data;
            mlast_next = rx_last;
          end
          // Payload is only staged; media holds it until commit
          if (idx_reg >= FR_LEN && qtyp_reg == REQ_WRITE) begin        // RULE4
            sval_next = 1'b1;
            sdat_next = rx_data;
          end
          if (rx_last) begin
            rdy_next   = 1'b0;
            short_next = (idx_reg < FR_TYP_HI);
            st_next    = ST_EVAL;
          end
        end else if (idx_reg == '0 && pend_reg) begin
          rdy_next = 1'b0;
          st_next  = ST_IDLE;
        end
      end
      ST_EVAL: begin
        st_next    = ST_IDLE;
        sdone_next = 1'b1;                                               // RULE17
        if (short_reg) begin
          rtyp_next = qtyp_reg;
          rres_next = RES_GENERAL;
        end else if (qtyp_reg == REQ_CNT_READ) begin                    // RULE1
          rtyp_next = RSP_CNT_READ;                                     // RULE3
          rres_next = RES_OK;
          radr_next = '0;
          rnon_next = nonce_reg;
        end else if (qtyp_reg == REQ_RESULT) begin                      // RULE12
          // Write outcome is already final here, so completion is safe
          rtyp_next = RSP_WRITE;                                        // RULE13
          rres_next = wres_reg;
          radr_next = wadr_reg;
          rnon_next = '0;
        end else if (qtyp_reg == REQ_WRITE) begin
          wadr_next = qadr_reg;
          if (ctr_reg == CNT_MAX) begin                                 // RULE18
            wres_next = RES_EXPIRED;                                    // RULE5
          end else if (qsc_reg == '0 || qadr_reg >= AREA_SIZE ||
                       qsc_reg > AREA_SIZE - qadr_reg) begin
            wres_next = RES_ADDRESS;                                    // RULE6
          end else begin
            sdone_next = 1'b0;
            mreq_next  = 1'b1;
            st_next    = ST_MAC;
          end
        end else begin
          rtyp_next = qtyp_reg;
          rres_next = RES_GENERAL;
        end
      end
      ST_MAC: begin
        if (mac_chk_done) begin
          st_next    = ST_IDLE;
          sdone_next = 1'b1;                                            // RULE11
          if (!mac_chk_ok) begin
            wres_next = RES_AUTH;                                       // RULE7
          end else if (qcnt_reg != ctr_reg) begin
            wres_next = RES_COUNTER;                                    // RULE8
          end else begin
            sdone_next  = 1'b0;
            commit_next = 1'b1;                                         // RULE9
            st_next     = ST_COMMIT;
          end
        end
      end
      ST_COMMIT: begin
        if (med_done) begin
          st_next    = ST_IDLE;
          sdone_next = 1'b1;                                            // RULE11
          if (med_fail) begin
            wres_next = RES_WRFAIL;                                     // RULE10
          end else if (med_err) begin
            wres_next = RES_GENERAL;                                    // RULE10
          end else begin
            wres_next = RES_OK;
            ctr_next  = ctr_reg + 32'h0000_0001;                        // RULE9
          end
        end
      end
      ST_GEN: begin
        mval_next = 1'b1;                                               // RULE16
        mdat_next = rbyte;
        idx_next  = idx_reg + 32'h0000_0001;
        if (idx_reg == FR_TYP_HI) begin
          mlast_next = 1'b1;
          st_next    = ST_GEN_WAIT;
        end
      end
      ST_GEN_WAIT: begin
        if (mac_gen_done) begin
          mgen_next = 1'b0;
          rmac_next = mac_gen_value;
          idx_next  = '0;
          st_next   = ST_TX;
        end
      end
      ST_TX: begin
        if (b_in.ready) begin                                           // RULE15
          idx_next = idx_reg + 32'h0000_0001;
          if (idx_reg == FR_TYP_HI) st_next = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        if (b_out.valid && tx_ready && b_out.last) begin
          rdone_next = 1'b1;                                            // RULE17
          st_next    = ST_IDLE;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_reg <= ST_IDLE;    idx_reg <= '0;        tgt_reg <= '0;
      nonce_reg <= '0;      qcnt_reg <= '0;       qadr_reg <= '0;
      qsc_reg <= '0;        qtyp_reg <= '0;       short_reg <= 1'b0;
      ctr_reg <= CNT_RESET; wres_reg <= RES_OK;   wadr_reg <= '0;
      rtyp_reg <= '0;       rres_reg <= RES_OK;   radr_reg <= '0;
      rnon_reg <= '0;       rmac_reg <= '0;       pend_reg <= 1'b0;
      rdy_reg <= 1'b0;      sdone_reg <= 1'b0;    rdone_reg <= 1'b0;
      mval_reg <= 1'b0;     mdat_reg <= '0;       mlast_reg <= 1'b0;
      mgen_reg <= 1'b0;     mreq_reg <= 1'b0;     sval_reg <= 1'b0;
      sdat_reg <= '0;       commit_reg <= 1'b0;
    end else begin
      st_reg <= st_next;    idx_reg <= idx_next;  tgt_reg <= tgt_next;
      nonce_reg <= nonce_next; qcnt_reg <= qcnt_next; qadr_reg <= qadr_next;
      qsc_reg <= qsc_next;  qtyp_reg <= qtyp_next; short_reg <= short_next;
      ctr_reg <= ctr_next;  wres_reg <= wres_next; wadr_reg <= wadr_next;
      rtyp_reg <= rtyp_next; rres_reg <= rres_next; radr_reg <= radr_next;
      rnon_reg <= rnon_next; rmac_reg <= rmac_next; pend_reg <= pend_next;
      rdy_reg <= rdy_next;  sdone_reg <= sdone_next; rdone_reg <= rdone_next;
      mval_reg <= mval_next; mdat_reg <= mdat_next; mlast_reg <= mlast_next;
      mgen_reg <= mgen_next; mreq_reg <= mreq_next; sval_reg <= sval_next;
      sdat_reg <= sdat_next; commit_reg <= commit_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign rx_ready    = rdy_reg;
  assign send_done   = sdone_reg;
  assign rcv_done    = rdone_reg;
  assign tx_valid    = b_out.valid;
  assign tx_data     = b_out.data;
  assign tx_last     = b_out.last;
  assign mac_valid   = mval_reg;
  assign mac_data    = mdat_reg;
  assign mac_last    = mlast_reg;
  assign mac_gen     = mgen_reg;
  assign mac_chk_req = mreq_reg;
  assign stg_valid   = sval_reg;
  assign stg_data    = sdat_reg;
  assign med_commit  = commit_reg;
  assign med_addr    = qadr_reg;
  assign med_count   = qsc_reg;
  assign wr_counter  = ctr_reg;
  assign busy        = (st_reg != ST_IDLE) && (st_reg != ST_RX);

endmodule

// [test/rpw_engine_props.sv]
/* Port checker for rpw_engine.
   Assumes a bind from the bench top and one clock domain. */
`timescale 1ns/1ps
module rpw_engine_props (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        rx_valid,
  input wire logic        rx_ready,
  input wire logic        rx_last,
  input wire logic        send_done,
  input wire logic        mac_chk_done,
  input wire logic        mac_chk_ok,
  input wire logic        med_commit,
  input wire logic        med_done,
  input wire logic        med_fail,
  input wire logic        med_err,
  input wire logic [31:0] wr_counter,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic        tx_last,
  input wire logic        rcv_done
);
  // ----
  // Properties
  // ----
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire ok_done = med_done && !med_fail && !med_err;
  chk_commit_mac_pass: assert property (med_commit |-> $past(mac_chk_done && mac_chk_ok))
    else $error("commit without mac pass");
  chk_bad_mac_stop: assert property (mac_chk_done && !mac_chk_ok |=> !med_commit [*4])
    else $error("commit after mac failure");
  chk_count_step: assert property (ok_done |=> wr_counter == $past(wr_counter) + 32'h0000_0001)
    else $error("counter not stepped by one");
  chk_count_hold: assert property (!ok_done |=> $stable(wr_counter))
    else $error("counter moved without good write");
  chk_send_wait: assert property (rx_valid && rx_ready && rx_last |=> !send_done ##[1:80] send_done)
    else $error("send completion early or missing");
  chk_med_send: assert property (med_done |=> send_done)
    else $error("no send completion after media");
  chk_done_ready: assert property (send_done |-> !rx_ready)
    else $error("frame taken during completion");
  chk_rcv_last: assert property (rcv_done |-> $past(tx_valid && tx_ready && tx_last))
    else $error("receive done without last byte");
endmodule

// [test/rpw_far_model.sv]
/* MAC engine and media unit model.
   Assumes one clock; latency and outcomes set by the bench. */
`timescale 1ns/1ps
module rpw_far_model #(parameter logic [255:0] MACV = {8{32'h5a3c_96e1}}) (
  input  wire logic    sys_clk,
  input  wire logic [3:0] lat,
  input  wire logic    ok,
  input  wire logic    fl,
  input  wire logic    er,
  input  wire logic    mac_chk_req,
  input  wire logic    gen_end,
  input  wire logic    med_commit,
  output logic         mac_chk_done = 0,
  output logic         mac_chk_ok = 0,
  output logic         mac_gen_done = 0,
  output logic [255:0] mac_gen_value = 0,
  output logic         med_done = 0,
  output logic         med_fail = 0,
  output logic         med_err = 0
);
  int tc = -1, tg = -1, tm = -1;
  // Qualifiers toggle outside done so a stale value never passes
  always @(posedge sys_clk) begin
    {mac_chk_done, mac_gen_done, med_done} <= 3'b000;
    {mac_chk_ok, med_fail, med_err} <= ~{mac_chk_ok, med_fail, med_err};
    mac_gen_value <= ~MACV;
    tc <= mac_chk_req ? lat : (tc >= 0 ? tc - 1 : -1);
    tg <= gen_end ? lat : (tg >= 0 ? tg - 1 : -1);
    tm <= med_commit ? lat : (tm >= 0 ? tm - 1 : -1);
    if (tc == 0) begin
      mac_chk_done <= 1;
      mac_chk_ok <= ok;
    end
    if (tg == 0) begin
      mac_gen_done <= 1;
      mac_gen_value <= MACV;
    end
    if (tm == 0) begin
      med_done <= 1;
      {med_fail, med_err} <= {fl, er};
    end
  end
endmodule

// [test/rpw_engine_bench.sv]
/* Self-checking bench for rpw_engine.
   Assumes the far model answers MAC and media requests. */
`timescale 1ns/1ps
module rpw_engine_bench;
  import rpw_pkg::*;
  localparam logic [255:0] MACV = {8{32'h5a3c_96e1}};
  logic sys_clk = 0, sys_rst = 1, rx_valid = 0, rx_last = 0, rcv_req = 0, tx_ready = 0;
  logic [7:0] rx_data = 0, tx_data;
  logic tx_valid, tx_last, rx_ready, send_done, rcv_done, mac_valid, mac_last, mac_gen;
  logic mac_chk_req, mac_chk_done, mac_chk_ok, mac_gen_done;
  logic med_commit, med_done, med_fail, med_err, ok = 1, fl = 0, er = 0;
  logic [255:0] mac_gen_value;
  logic [31:0] wr_counter, med_addr;
  logic [3:0] lat = 0;
  logic [7:0] fr [0:259];
  logic [7:0] rs [0:255];
  int errors = 0, n_tests = 0, cnt = 0;
  always #2 sys_clk = ~sys_clk;
  // Small area keeps address faults reachable
  rpw_engine #(.AREA_SIZE(32'h0000_0010)) rpw_engine_inst (.*, .mac_data(), .stg_valid(),
    .stg_data(), .med_count(), .busy());
  rpw_far_model #(.MACV(MACV)) rpw_far_model_inst (.sys_clk(sys_clk), .lat(lat), .ok(ok),
    .fl(fl), .er(er), .mac_chk_req(mac_chk_req), .gen_end(mac_valid && mac_last && mac_gen),
    .med_commit(med_commit), .mac_chk_done(mac_chk_done), .mac_chk_ok(mac_chk_ok),
    .mac_gen_done(mac_gen_done), .mac_gen_value(mac_gen_value), .med_done(med_done),
    .med_fail(med_fail), .med_err(med_err));
  // ----
  // Tasks
  // ----
  task chk(string nm, logic [31:0] s, logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s exp %h got %h", nm, e, s);
    end
  endtask
  task end_sim;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic [31:0] f32(int b);
    return {rs[b+3], rs[b+2], rs[b+1], rs[b]};
  endfunction
  task mk(logic [15:0] ty, logic [31:0] wc, logic [31:0] ad, logic [31:0] sc);
    foreach (fr[i]) fr[i] = 8'h00;
    fr[223] = 8'h07;
    {fr[243], fr[242], fr[241], fr[240]} = wc;
    {fr[247], fr[246], fr[245], fr[244]} = ad;
    {fr[251], fr[250], fr[249], fr[248]} = sc;
    {fr[255], fr[254]} = ty;
  endtask
  task send(int n);
    for (int i = 0; i < n; i++) begin
      rx_valid = 1;
      rx_data = fr[i];
      rx_last = (i == n - 1);
      while (!rx_ready) @(negedge sys_clk);
      @(negedge sys_clk);
    end
    rx_valid = 0;
    rx_last = 0;
    for (int k = 0; k < 200 && !send_done; k++) @(negedge sys_clk);
    chk("send_done", send_done, 1);
    @(negedge sys_clk);
  endtask
  task recv;
    int k;
    k = 0;
    rcv_req = 1;
    @(negedge sys_clk);
    rcv_req = 0;
    for (int c = 0; c < 3000 && !rcv_done; c++) begin
      tx_ready = ($urandom % 3) != 0;
      if (tx_valid && tx_ready && k < 256) begin
        rs[k] = tx_data;
        k++;
      end
      @(negedge sys_clk);
    end
    tx_ready = 0;
    chk("rcv_done", rcv_done, 1);
    chk("bytes", k, 256);
    chk("target", rs[223], 8'h07);
    chk("mac", rs[191], MACV[7:0]);
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    int ad, sc, wc;
    logic [15:0] e;
    void'($urandom(32'h0ab1_5840));
    repeat (2) @(negedge sys_clk);
    sys_rst = 0;
    chk("wr_counter", wr_counter, 0);
    mk(REQ_CNT_READ, 0, 0, 0);
    for (int i = 224; i < 240; i++) fr[i] = 8'($urandom);
    send(256);
    recv;
    chk("type", {rs[255], rs[254]}, RSP_CNT_READ);
    chk("nonce", f32(224), {fr[227], fr[226], fr[225], fr[224]});
    chk("counter", f32(240), cnt);
    for (int t = 0; t < 20; t++) begin
      ad = $urandom % 20;
      sc = $urandom % 3;
      wc = cnt + int'($urandom % 4 == 0);
      {ok, fl, er} = {$urandom % 4 != 0, $urandom % 5 == 0, $urandom % 5 == 0};
      lat = 4'($urandom);
      mk(REQ_WRITE, wc, ad, sc);
      for (int i = 256; i < 260; i++) fr[i] = 8'($urandom);
      send(260);
      if (ad >= 16 || ad + sc > 16 || sc == 0) e = RES_ADDRESS;
      else if (!ok) e = RES_AUTH;
      else if (wc != cnt) e = RES_COUNTER;
      else if (fl) e = RES_WRFAIL;
      else if (er) e = RES_GENERAL;
      else begin
        e = RES_OK;
        cnt++;
      end
      chk("wr_counter", wr_counter, cnt);
      chk("addr", med_addr, ad);
      mk(REQ_RESULT, 0, 0, 0);
      send(256);
      recv;
      chk("type", {rs[255], rs[254]}, RSP_WRITE);
      chk("result", {rs[253], rs[252]}, e);
      chk("counter", f32(240), cnt);
      if (e == RES_OK) chk("address", f32(244), ad);
    end
    end_sim;
  end
  initial begin
    repeat (90000) @(posedge sys_clk);
    errors++;
    end_sim;
  end
endmodule
bind rpw_engine rpw_engine_props rpw_engine_props_inst (.*);
